// File: dio_input_gearing.sv
`timescale 1ns/1ns
module dio_input_gearing
  import dio_pkg::*;
(
  // edge clock domain
  input wire logic clk_in,
  input wire logic rst_in,
  // beats from the queue
  input wire logic beat_valid_in,
  input wire logic [DIO_BEAT_W-1:0] beat_in,
  // configuration and alignment
  input wire dio_in_ratio_e ratio_in,
  input wire logic align_in,
  // parallel word
  output logic [DIO_WORD_W-1:0] word_out,
  output logic word_valid_out
);

  logic [DIO_GEAR_BUF_W-1:0] buf_q;
  logic [DIO_GEAR_BUF_W-1:0] buf_d;
  logic [DIO_GEAR_CNT_W-1:0] cnt_q;
  logic [DIO_GEAR_CNT_W-1:0] cnt_d;
  logic [DIO_GEAR_CNT_W-1:0] bits;
  logic [DIO_GEAR_BUF_W-1:0] shifted;
  logic emit;
  logic pend_q;
  logic take;

  always_comb begin
    unique case (ratio_in)
      DIO_IN_R2: bits = DIO_BITS_2;
      DIO_IN_R4: bits = DIO_BITS_4;
      DIO_IN_R7: bits = DIO_BITS_7;
      default: bits = DIO_BITS_2;
    endcase
  end

  always_comb begin
    buf_d = buf_q;
    cnt_d = cnt_q;
    if (beat_valid_in) begin
      buf_d = {buf_q[DIO_GEAR_BUF_W-DIO_BEAT_W-1:0], beat_in};
      cnt_d = cnt_q + DIO_GEAR_CNT_W'(DIO_BEAT_W);
    end
    // dropping the oldest bit moves the word boundary by one
    // a request with nothing buffered waits for the next beat
    take = (align_in || pend_q) && (cnt_d != '0);
    if (take) begin
      cnt_d = cnt_d - 5'h01;
    end
    emit = (cnt_d >= bits);
    shifted = buf_d >> (emit ? (cnt_d - bits) : 5'h00);
    if (emit) begin
      cnt_d = cnt_d - bits;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      buf_q <= '0;
      cnt_q <= '0;
      pend_q <= 1'b0;
      word_valid_out <= 1'b0;
      word_out <= '0;
    end else begin
      pend_q <= (align_in || pend_q) && !take;
      buf_q <= buf_d;
      cnt_q <= cnt_d;
      word_valid_out <= emit;
      if (emit) begin
        // unused upper bits read as zero for the short ratios
        word_out <= shifted[DIO_WORD_W-1:0] &
          DIO_WORD_W'((8'h01 << bits) - 8'h01);
      end
    end
  end

endmodule

// File: dio_io_cell.sv
`timescale 1ns/1ns
module dio_io_cell
  import dio_pkg::*;
#(
  parameter int PINS = DIO_DQ_PINS,
  parameter bit TOP_EDGE = 1'b0
) (
  // core clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // group clocks
  input wire logic dqs_delayed_clk_in,
  input wire logic high_speed_edge_clock_in,
  input wire logic strobe_write_clock_in,
  input wire logic data_write_clock_in,
  // memory side pins
  input wire logic [PINS-1:0] dq_in,
  output logic [PINS-1:0] dq_out,
  output logic [PINS-1:0] tristate_block_output_out,
  output logic strobe_out,
  output logic strobe_oe_out,
  // core read path
  input wire dio_in_ratio_e in_ratio_in,
  input wire logic word_align_request_in,
  output logic [PINS*DIO_WORD_W-1:0] core_word_out,
  output logic core_word_valid_out,
  // core write path
  input wire dio_out_gear_e out_gear_in,
  input wire logic [PINS*DIO_WORD_W-1:0] out_word_in,
  input wire logic [1:0] tristate_control_input_in,
  input wire logic out_valid_in,
  output logic out_ready_out
);

  // ---------------- core domain reset ----------------
  // held one cycle past rst_n so the other domains see a clean pulse
  logic clr_q;

  always_ff @(posedge sys_clk_in) begin
    clr_q <= ~rst_n_in;
  end

  // ---------------- strobe domain pointer ----------------
  // strobe stops between bursts, so the clear acts without its edges
  logic [DIO_PTR_W-1:0] fifo_write_pointer;
  logic [DIO_PTR_W-1:0] wr_gray_q;

  always_ff @(negedge dqs_delayed_clk_in or posedge clr_q) begin
    if (clr_q) begin
      fifo_write_pointer <= DIO_WR_PTR_RST;
      wr_gray_q <= DIO_WR_PTR_RST;
    end else begin
      fifo_write_pointer <= fifo_write_pointer + 3'h1;
      wr_gray_q <= (fifo_write_pointer + 3'h1) ^
        ((fifo_write_pointer + 3'h1) >> 1);
    end
  end

  // ---------------- edge clock domain ----------------
  logic edge_rst_s1_q;
  logic edge_rst_q;
  logic [DIO_PTR_W-1:0] wr_gray_s1_q;
  logic [DIO_PTR_W-1:0] wr_gray_s2_q;
  logic [DIO_PTR_W-1:0] wr_bin;
  logic [DIO_PTR_W-1:0] fifo_read_pointer;
  logic rd_en;
  logic beat_valid_q;
  dio_in_ratio_e ratio_s1_q;
  dio_in_ratio_e ratio_s2_q;

  always_ff @(posedge high_speed_edge_clock_in) begin
    edge_rst_s1_q <= clr_q;
    edge_rst_q <= edge_rst_s1_q;
    wr_gray_s1_q <= wr_gray_q;
    wr_gray_s2_q <= wr_gray_s1_q;
    ratio_s1_q <= in_ratio_in;
    ratio_s2_q <= ratio_s1_q;
  end

  always_comb begin
    wr_bin[DIO_PTR_W-1] = wr_gray_s2_q[DIO_PTR_W-1];
    for (int i = DIO_PTR_W - 2; i >= 0; i--) begin
      wr_bin[i] = wr_bin[i+1] ^ wr_gray_s2_q[i];
    end
  end

  // read only behind the write pointer, so no entry is read twice
  assign rd_en = ~edge_rst_q && (fifo_read_pointer != wr_bin);

  always_ff @(posedge high_speed_edge_clock_in) begin
    if (edge_rst_q) begin
      fifo_read_pointer <= DIO_RD_PTR_RST;
      beat_valid_q <= 1'b0;
    end else begin
      beat_valid_q <= rd_en;
      if (rd_en) begin
        fifo_read_pointer <= fifo_read_pointer + 3'h1;
      end
    end
  end

  // ---------------- align request, core to edge ----------------
  logic align_tgl_q;
  logic align_s1_q;
  logic align_s2_q;
  logic align_s3_q;
  logic align_pulse;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      align_tgl_q <= 1'b0;
    end else if (word_align_request_in) begin
      align_tgl_q <= ~align_tgl_q;
    end
  end

  always_ff @(posedge high_speed_edge_clock_in) begin
    align_s1_q <= align_tgl_q;
    align_s2_q <= align_s1_q;
    align_s3_q <= align_s2_q;
  end

  assign align_pulse = align_s2_q ^ align_s3_q;

  // ---------------- per pin queue and gearing ----------------
  logic [PINS*DIO_BEAT_W-1:0] beats;
  logic [PINS*DIO_WORD_W-1:0] gear_words;
  logic gear_valid;

  for (genvar p = 0; p < PINS; p++) begin : g_pin
    dio_pin_input_queue u_queue (
      .strobe_clk_in(dqs_delayed_clk_in),
      .clr_in(clr_q),
      .fifo_write_pointer_in(fifo_write_pointer),
      .d_in(dq_in[p]),
      .edge_clk_in(high_speed_edge_clock_in),
      .rd_en_in(rd_en),
      .fifo_read_pointer_in(fifo_read_pointer),
      .beat_out(beats[p*DIO_BEAT_W +: DIO_BEAT_W])
    );

    if (p == 0) begin : g_lead
      dio_input_gearing u_gear (
        .clk_in(high_speed_edge_clock_in),
        .rst_in(edge_rst_q),
        .beat_valid_in(beat_valid_q),
        .beat_in(beats[p*DIO_BEAT_W +: DIO_BEAT_W]),
        .ratio_in(ratio_s2_q),
        .align_in(align_pulse),
        .word_out(gear_words[p*DIO_WORD_W +: DIO_WORD_W]),
        .word_valid_out(gear_valid)
      );
    end else begin : g_follow
      dio_input_gearing u_gear (
        .clk_in(high_speed_edge_clock_in),
        .rst_in(edge_rst_q),
        .beat_valid_in(beat_valid_q),
        .beat_in(beats[p*DIO_BEAT_W +: DIO_BEAT_W]),
        .ratio_in(ratio_s2_q),
        .align_in(align_pulse),
        .word_out(gear_words[p*DIO_WORD_W +: DIO_WORD_W]),
        .word_valid_out()
      );
    end
  end

  // ---------------- words, edge to core ----------------
  // a word that arrives while the previous is unacknowledged is dropped
  logic [PINS*DIO_WORD_W-1:0] hold_q;
  logic req_q;
  logic ack_e1_q;
  logic ack_e2_q;
  logic req_s1_q;
  logic req_s2_q;
  logic req_s3_q;
  logic ack_q;

  always_ff @(posedge high_speed_edge_clock_in) begin
    ack_e1_q <= ack_q;
    ack_e2_q <= ack_e1_q;
  end

  always_ff @(posedge high_speed_edge_clock_in) begin
    if (edge_rst_q) begin
      req_q <= 1'b0;
      hold_q <= '0;
    end else if (gear_valid && (req_q == ack_e2_q)) begin
      hold_q <= gear_words;
      req_q <= ~req_q;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    req_s1_q <= req_q;
    req_s2_q <= req_s1_q;
    req_s3_q <= req_s2_q;
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
      core_word_valid_out <= 1'b0;
      core_word_out <= '0;
    end else begin
      core_word_valid_out <= req_s2_q ^ req_s3_q;
      if (req_s2_q ^ req_s3_q) begin
        core_word_out <= hold_q;
        ack_q <= req_s2_q;
      end
    end
  end

  // ---------------- output path, core side ----------------
  logic [PINS*DIO_WORD_W-1:0] out_word_q;
  logic [1:0] tri_q;
  dio_out_gear_e gear_q;
  logic out_tgl_q;
  logic done_s1_q;
  logic done_s2_q;
  logic done_q;

  always_ff @(posedge sys_clk_in) begin
    done_s1_q <= done_q;
    done_s2_q <= done_s1_q;
  end

  assign out_ready_out = (out_tgl_q == done_s2_q);

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      out_tgl_q <= 1'b0;
      out_word_q <= '0;
      tri_q <= 2'h3;
      gear_q <= DIO_OUT_X1;
    end else if (out_valid_in && out_ready_out) begin
      out_word_q <= out_word_in;
      tri_q <= tristate_control_input_in;
      // top edge cells have no serialiser
      gear_q <= TOP_EDGE ? DIO_OUT_X1 : out_gear_in;
      out_tgl_q <= ~out_tgl_q;
    end
  end

  // ---------------- data write clock domain ----------------
  logic dw_rst_s1_q;
  logic dw_rst_q;
  logic go_s1_q;
  logic go_s2_q;
  dio_os_state_e os_q;
  logic [PINS*DIO_WORD_W-1:0] shift_q;
  logic [DIO_GEAR_CNT_W-1:0] left_q;
  logic [DIO_GEAR_CNT_W-1:0] out_bits;
  logic phase_q;
  logic t_bit;

  always_ff @(posedge data_write_clock_in) begin
    dw_rst_s1_q <= clr_q;
    dw_rst_q <= dw_rst_s1_q;
    go_s1_q <= out_tgl_q;
    go_s2_q <= go_s1_q;
  end

  always_comb begin
    unique case (gear_q)
      DIO_OUT_X1: out_bits = DIO_BITS_1;
      DIO_OUT_X2: out_bits = DIO_BITS_2;
      DIO_OUT_7TO1: out_bits = DIO_BITS_7;
      default: out_bits = DIO_BITS_1;
    endcase
  end

  // single rate uses one tristate bit, double rate alternates two
  assign t_bit = (gear_q == DIO_OUT_X1) ? tri_q[0] : tri_q[phase_q];

  always_ff @(posedge data_write_clock_in) begin
    if (dw_rst_q) begin
      os_q <= DIO_OS_IDLE;
      done_q <= 1'b0;
      shift_q <= '0;
      left_q <= '0;
      phase_q <= 1'b0;
    end else begin
      unique case (os_q)
        DIO_OS_IDLE: begin
          phase_q <= 1'b0;
          if (go_s2_q != done_q) begin
            shift_q <= out_word_q;
            left_q <= out_bits;
            os_q <= DIO_OS_SHIFT;
          end
        end
        DIO_OS_SHIFT: begin
          for (int p = 0; p < PINS; p++) begin
            shift_q[p*DIO_WORD_W +: DIO_WORD_W] <=
              {shift_q[p*DIO_WORD_W +: DIO_WORD_W-1], 1'b0};
          end
          phase_q <= ~phase_q;
          left_q <= left_q - 5'h01;
          if (left_q == 5'h01) begin
            done_q <= go_s2_q;
            os_q <= DIO_OS_IDLE;
          end
        end
      endcase
    end
  end

  // bits leave msb first, from bit out_bits-1 of each pin's word
  always_ff @(posedge data_write_clock_in) begin
    if (dw_rst_q) begin
      dq_out <= '0;
      tristate_block_output_out <= '0;
    end else if (os_q == DIO_OS_SHIFT) begin
      for (int p = 0; p < PINS; p++) begin
        dq_out[p] <= shift_q[p*DIO_WORD_W + int'(out_bits) - 1];
      end
      tristate_block_output_out <= {PINS{~t_bit}};
    end else begin
      tristate_block_output_out <= '0;
    end
  end

  // ---------------- strobe write clock domain ----------------
  // data clock lags the strobe clock by 90 degrees, centring data on it
  logic sw_rst_s1_q;
  logic sw_rst_q;
  logic act_s1_q;
  logic act_s2_q;

  always_ff @(posedge strobe_write_clock_in) begin
    sw_rst_s1_q <= clr_q;
    sw_rst_q <= sw_rst_s1_q;
    act_s1_q <= |tristate_block_output_out;
    act_s2_q <= act_s1_q;
  end

  always_ff @(posedge strobe_write_clock_in) begin
    if (sw_rst_q) begin
      strobe_out <= 1'b0;
      strobe_oe_out <= 1'b0;
    end else begin
      strobe_oe_out <= act_s2_q;
      strobe_out <= act_s2_q ? ~strobe_out : 1'b0;
    end
  end

endmodule

// File: dio_io_cell_bench.sv
`timescale 1ns/1ns
module dio_io_cell_bench
  import dio_pkg::*;
;
  typedef struct {dio_in_ratio_e r; int n; int nb; int bl;} dio_rrow_s;
  typedef struct {dio_out_gear_e g; logic [1:0] t; int n; int cnt;} dio_wrow_s;
  // one word per burst at most: the core handshake is slower than a beat
  dio_rrow_s rrows[3] = '{'{DIO_IN_R2, 2, 2, 1}, '{DIO_IN_R7, 7, 7, 1},
    '{DIO_IN_R4, 4, 2, 2}};
  dio_wrow_s wrows[5] = '{'{DIO_OUT_X1, 2'h0, 1, 1},
    '{DIO_OUT_X2, 2'h0, 2, 2}, '{DIO_OUT_7TO1, 2'h0, 7, 7},
    '{DIO_OUT_X2, 2'h2, 2, 1}, '{DIO_OUT_X1, 2'h1, 1, 0}};
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic hs_clk = 1'h0;
  wire dw_clk;
  logic rd_strobe;
  logic [7:0] dq_rd;
  logic [7:0] dq_wr;
  logic [7:0] oe;
  logic strobe;
  logic strobe_oe;
  dio_in_ratio_e ratio = DIO_IN_R2;
  logic align = 1'h0;
  logic [55:0] word;
  logic word_valid;
  dio_out_gear_e gear = DIO_OUT_X1;
  logic [55:0] wr_word = 56'h0;
  logic [1:0] tri_ctl = 2'h0;
  logic wr_valid = 1'h0;
  logic wr_ready;
  int fail_count = 0;
  int comparisons = 0;
  int idx = 0;
  logic [55:0] got_q[$];
  logic [7:0] drv_q[$];
  logic [7:0] bits[$];

  always #5 sys_clk = ~sys_clk;
  always #6 hs_clk = ~hs_clk;
  assign #3 dw_clk = hs_clk;

  dio_io_cell i_dut (
    .sys_clk_in(sys_clk),
    .rst_n_in(rst_n),
    .dqs_delayed_clk_in(rd_strobe),
    .high_speed_edge_clock_in(hs_clk),
    .strobe_write_clock_in(hs_clk),
    .data_write_clock_in(dw_clk),
    .dq_in(dq_rd),
    .dq_out(dq_wr),
    .tristate_block_output_out(oe),
    .strobe_out(strobe),
    .strobe_oe_out(strobe_oe),
    .in_ratio_in(ratio),
    .word_align_request_in(align),
    .core_word_out(word),
    .core_word_valid_out(word_valid),
    .out_gear_in(gear),
    .out_word_in(wr_word),
    .tristate_control_input_in(tri_ctl),
    .out_valid_in(wr_valid),
    .out_ready_out(wr_ready)
  );

  dio_mem_model i_mem (
    .rd_strobe_out(rd_strobe),
    .rd_dq_out(dq_rd),
    .strobe_in(strobe),
    .strobe_oe_in(strobe_oe)
  );

  always @(posedge sys_clk) if (word_valid === 1'h1) got_q.push_back(word);
  always @(negedge dw_clk) if (oe !== 8'h00) drv_q.push_back(dq_wr);

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 5);
  endfunction

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      $display("ERROR t=%0t got=%0h exp=%0h", $time, g, e);
      fail_count++;
    end
  endtask

  task automatic tmo();
    fail_count++;
    summarize();
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst_n <= 1'h0;
    repeat (7) @(posedge sys_clk);
    rst_n <= 1'h1;
    repeat (10) @(posedge sys_clk);
  endtask

  task automatic wait_ready();
    int k;
    for (k = 0; k < 80; k++) begin
      @(negedge sys_clk);
      if (wr_ready === 1'h1) break;
    end
    if (k == 80) tmo();
  endtask

  // r.nb bursts of reads, words rebuilt from the sent bit stream
  task automatic rd(input dio_rrow_s r, input int skip);
    logic [7:0] q[$];
    logic [55:0] e;
    logic [55:0] m;
    int nw;
    int k;
    bits.delete();
    got_q.delete();
    @(posedge sys_clk);
    ratio <= r.r;
    repeat (5) @(posedge sys_clk);
    for (int b = 0; b < r.nb; b++) begin
      q.delete();
      repeat (r.bl * 2) q.push_back(pat(idx++));
      bits = {bits, q};
      i_mem.burst(q);
      repeat (12) @(posedge sys_clk);
    end
    nw = (r.nb * r.bl * 2 - skip) / r.n;
    for (k = 0; k < 300 && got_q.size() < nw; k++) @(posedge sys_clk);
    if (k == 300) tmo();
    repeat (20) @(posedge sys_clk);
    chk(got_q.size(), nw);
    for (int w = 0; w < nw; w++) begin
      e = 56'h0;
      m = 56'h0;
      for (int p = 0; p < 8; p++)
        for (int j = 0; j < r.n; j++) begin
          e[p * 7 + r.n - 1 - j] = bits[skip + w * r.n + j][p];
          m[p * 7 + r.n - 1 - j] = 1'h1;
        end
      chk(got_q[w] & m, e);
    end
  endtask

  task automatic wr(input dio_wrow_s r);
    logic [55:0] w;
    w = {pat(r.n), pat(r.n + 1), pat(r.n + 2), pat(r.n + 3),
      pat(r.n + 4), pat(r.n + 5), pat(r.n + 6)};
    drv_q.delete();
    @(posedge sys_clk);
    gear <= r.g;
    tri_ctl <= r.t;
    wr_word <= w;
    wr_valid <= 1'h1;
    wait_ready();
    @(posedge sys_clk);
    wr_valid <= 1'h0;
    wait_ready();
    repeat (4) @(negedge dw_clk);
    chk(drv_q.size(), r.cnt);
    foreach (drv_q[i])
      for (int p = 0; p < 8; p++)
        chk(drv_q[i][p], w[p * 7 + r.n - 1 - i]);
  endtask

  initial begin
    repeat (7) @(posedge sys_clk);
    rst_n <= 1'h1;
    @(negedge sys_clk);
    chk(wr_ready, 1'h1);
    chk(oe, 8'h00);
    repeat (10) @(posedge sys_clk);
    foreach (rrows[i]) rd(rrows[i], 0);
    foreach (wrows[i]) wr(wrows[i]);
    chk(i_mem.strobe_edges > 0, 1'h1);
    // one dropped bit moves every later word boundary
    @(posedge sys_clk);
    align <= 1'h1;
    @(posedge sys_clk);
    align <= 1'h0;
    rd('{DIO_IN_R4, 4, 3, 2}, 1);
    // leftover bits must not survive a reset
    do_reset();
    rd(rrows[2], 0);
    summarize();
  end
endmodule

// File: dio_io_cell_props.sv
`timescale 1ns/1ns
module dio_io_cell_props
  import dio_pkg::*;
#(
  parameter int PINS = DIO_DQ_PINS
) (
  // clocks and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic strobe_write_clock_in,
  input wire logic data_write_clock_in,
  // watched ports
  input wire logic [PINS-1:0] tristate_block_output_out,
  input wire logic strobe_out,
  input wire logic strobe_oe_out,
  input wire logic [PINS*DIO_WORD_W-1:0] core_word_out,
  input wire logic core_word_valid_out,
  input wire logic out_valid_in,
  input wire logic out_ready_out
);
  a_valid_one_pulse: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) core_word_valid_out |=> !core_word_valid_out)
    else $error("word valid wider than one cycle");
  a_word_holds: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) !core_word_valid_out |-> $stable(core_word_out))
    else $error("word changed without valid");
  a_take_drops_ready: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) out_valid_in && out_ready_out |=> !out_ready_out)
    else $error("ready stayed high after take");
  a_ready_returns: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $fell(out_ready_out) |-> ##[1:40] out_ready_out)
    else $error("ready did not return");
  a_reset_clears_oe: assert property (@(posedge sys_clk_in)
    !rst_n_in [*6] |-> tristate_block_output_out == '0 && !strobe_oe_out)
    else $error("enable set during reset");
  a_no_stale_word: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) $rose(rst_n_in) |-> !core_word_valid_out [*8])
    else $error("word right after reset");
  a_idle_no_oe: assert property (@(posedge sys_clk_in)
    disable iff (!rst_n_in) out_ready_out [*5] |-> !(|tristate_block_output_out))
    else $error("enable while idle");
  a_oe_same_all: assert property (@(posedge data_write_clock_in)
    disable iff (!rst_n_in) !(|tristate_block_output_out)
    || (&tristate_block_output_out))
    else $error("pins disagree on enable");
  a_strobe_toggles: assert property (@(posedge strobe_write_clock_in)
    disable iff (!rst_n_in) $past(strobe_oe_out) && strobe_oe_out
    |-> strobe_out != $past(strobe_out))
    else $error("strobe did not toggle");
endmodule

bind dio_io_cell dio_io_cell_props #(.PINS(PINS)) i_props (
  .sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in),
  .strobe_write_clock_in(strobe_write_clock_in),
  .data_write_clock_in(data_write_clock_in),
  .tristate_block_output_out(tristate_block_output_out),
  .strobe_out(strobe_out),
  .strobe_oe_out(strobe_oe_out),
  .core_word_out(core_word_out),
  .core_word_valid_out(core_word_valid_out),
  .out_valid_in(out_valid_in),
  .out_ready_out(out_ready_out)
);

// File: dio_mem_model.sv
`timescale 1ns/1ns
module dio_mem_model
  import dio_pkg::*;
(
  // read strobe and data
  output logic rd_strobe_out,
  output logic [DIO_DQ_PINS-1:0] rd_dq_out,
  // write strobe from the cell
  input wire logic strobe_in,
  input wire logic strobe_oe_in
);
  logic busy = 1'h0;
  int strobe_edges = 0;

  initial rd_strobe_out = 1'h0;
  initial rd_dq_out = 8'h5A;
  // released data keeps moving so stale bits never match
  always #6 if (!busy) rd_dq_out = ~rd_dq_out;
  always @(strobe_in) if (strobe_oe_in) strobe_edges++;

  // strobe still between bursts, period equal to edge clock
  task automatic burst(input logic [7:0] b[$]);
    busy = 1'h1;
    for (int i = 0; i < b.size(); i += 2) begin
      rd_dq_out = b[i];
      #3 rd_strobe_out = 1'h1;
      #3 rd_dq_out = b[i+1];
      #3 rd_strobe_out = 1'h0;
      #3;
    end
    busy = 1'h0;
  endtask
endmodule

// File: dio_pin_input_queue.sv
`timescale 1ns/1ns
module dio_pin_input_queue
  import dio_pkg::*;
#(
  parameter int DEPTH = DIO_QUEUE_DEPTH,
  parameter int PTR_W = DIO_PTR_W
) (
  // strobe side
  input wire logic strobe_clk_in,
  input wire logic clr_in,
  input wire logic [PTR_W-1:0] fifo_write_pointer_in,
  input wire logic d_in,
  // edge clock side
  input wire logic edge_clk_in,
  input wire logic rd_en_in,
  input wire logic [PTR_W-1:0] fifo_read_pointer_in,
  output logic [DIO_BEAT_W-1:0] beat_out
);

  logic rise_q;
  logic [DIO_BEAT_W-1:0] mem [DEPTH];

  always_ff @(posedge strobe_clk_in or posedge clr_in) begin
    if (clr_in) begin
      rise_q <= 1'b0;
    end else begin
      rise_q <= d_in;
    end
  end

  // whole beat written on the falling edge, so the last beat is not lost
  always_ff @(negedge strobe_clk_in) begin
    mem[fifo_write_pointer_in] <= {rise_q, d_in};
  end

  // entries are only read once the synchronised write pointer passed them
  always_ff @(posedge edge_clk_in) begin
    if (rd_en_in) begin
      beat_out <= mem[fifo_read_pointer_in];
    end
  end

endmodule

// File: dio_pkg.sv
package dio_pkg;

  // queue geometry and pointer reset values
  localparam int DIO_PTR_W = 3;
  localparam int DIO_QUEUE_DEPTH = 8;
  localparam logic [2:0] DIO_WR_PTR_RST = 3'h0;
  localparam logic [2:0] DIO_RD_PTR_RST = 3'h0;

  // one memory beat is a rise bit and a fall bit
  localparam int DIO_BEAT_W = 2;
  localparam int DIO_WORD_W = 7;
  localparam int DIO_GEAR_BUF_W = 16;
  localparam int DIO_GEAR_CNT_W = 5;
  localparam int DIO_DQ_PINS = 8;

  // bit counts per gearing ratio
  localparam logic [4:0] DIO_BITS_1 = 5'h01;
  localparam logic [4:0] DIO_BITS_2 = 5'h02;
  localparam logic [4:0] DIO_BITS_4 = 5'h04;
  localparam logic [4:0] DIO_BITS_7 = 5'h07;

  typedef enum logic [2:0] {
    DIO_IN_R2 = 3'h1,
    DIO_IN_R4 = 3'h2,
    DIO_IN_R7 = 3'h4
  } dio_in_ratio_e;

  typedef enum logic [2:0] {
    DIO_OUT_X1 = 3'h1,
    DIO_OUT_X2 = 3'h2,
    DIO_OUT_7TO1 = 3'h4
  } dio_out_gear_e;

  typedef enum logic [1:0] {
    DIO_OS_IDLE = 2'h1,
    DIO_OS_SHIFT = 2'h2
  } dio_os_state_e;

endpackage
